//--- rtl/giq_input_qualifier.sv
`timescale 1ns/1ps
`default_nettype none
`include "giq_consts.svh"

module giq_input_qualifier (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] pinIn,
    output logic [31:0] pinOutLatch,
    output logic [31:0] periphIn
);
    // True when all bits of the used window agree
    function automatic logic windowAgrees(input logic [5:0] win, input logic six);
        logic [5:0] used;
        used = six ? win : {3'b000, win[2:0]};
        if (six) begin
            windowAgrees = (used == 6'h00) || (used == 6'h3F);
        end else begin
            windowAgrees = (used[2:0] == 3'h0) || (used[2:0] == 3'h7);
        end
    endfunction : windowAgrees

    // Word-aligned register hit
    function automatic logic regHit(input logic [7:0] addr, input logic [7:0] off);
        regHit = (addr[7:2] == off[7:2]);
    endfunction : regHit

    // Register file
    logic [31:0] qselLo_ff;
    logic [31:0] qselHi_ff;
    logic [31:0] periodCtl_ff;
    logic [31:0] outLatch_ff;
    logic [31:0] routeEn_ff;
    logic [31:0] dfltLvl_ff;

    // Bus pipeline
    logic wrPend_ff;
    logic [7:0] wrAddr_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;

    // Pin path
    logic [31:0] sync1_ff;
    logic [31:0] sync2_ff;
    logic [31:0][5:0] hist_ff;
    logic [31:0] qual_ff;
    logic [31:0] periph_ff;
    logic [3:0] grpTick;

    // Address phase decode
    wire accept = hsel && htrans[1] && hready;
    wire [7:0] aAddr = haddr[7:0];
    wire wordSize = (hsize == `GIQ_HSIZE_WORD);
    wire nxt_wrPend = accept && hwrite && wordSize;
    wire rdAccept = accept && !hwrite;

    // Data phase write strobes
    wire wrQselLo = wrPend_ff && regHit(wrAddr_ff, `GIQ_OFF_QSEL_LO);
    wire wrQselHi = wrPend_ff && regHit(wrAddr_ff, `GIQ_OFF_QSEL_HI);
    wire wrCtrl = wrPend_ff && regHit(wrAddr_ff, `GIQ_OFF_CTRL);
    wire wrData = wrPend_ff && regHit(wrAddr_ff, `GIQ_OFF_DATA); // see RULE11
    wire wrRoute = wrPend_ff && regHit(wrAddr_ff, `GIQ_OFF_ROUTE);
    wire wrDflt = wrPend_ff && regHit(wrAddr_ff, `GIQ_OFF_DFLT);
    // Registers sit in the low 32 bytes only
    wire hiZero = (aAddr[7:5] == 3'h0);

    // Address phase register hits, at most one true
    wire rdHitQselLo = hiZero && regHit(aAddr, `GIQ_OFF_QSEL_LO);
    wire rdHitQselHi = hiZero && regHit(aAddr, `GIQ_OFF_QSEL_HI);
    wire rdHitCtrl = hiZero && regHit(aAddr, `GIQ_OFF_CTRL);
    wire rdHitData = hiZero && regHit(aAddr, `GIQ_OFF_DATA); // see RULE11
    wire rdHitRoute = hiZero && regHit(aAddr, `GIQ_OFF_ROUTE);
    wire rdHitDflt = hiZero && regHit(aAddr, `GIQ_OFF_DFLT);

    // Read mux, unmapped reads zero; data address shows the peripheral input levels, default level for unrouted pins
    wire [31:0] nxt_hrdata =
        ({32{rdHitQselLo}} & qselLo_ff) |
        ({32{rdHitQselHi}} & qselHi_ff) |
        ({32{rdHitCtrl}} & periodCtl_ff) |
        ({32{rdHitData}} & periph_ff) | // see RULE11
        ({32{rdHitRoute}} & routeEn_ff) |
        ({32{rdHitDflt}} & dfltLvl_ff);

    // Write request carried into the data phase
    always_ff @(posedge mclk) begin
        if (srst) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
        end else if (clkEn) begin
            wrPend_ff <= nxt_wrPend && hiZero;
            wrAddr_ff <= aAddr;
        end
    end

    // Read data loaded in the address phase, held until the next read
    always_ff @(posedge mclk) begin
        if (srst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (clkEn && rdAccept) begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    // Zero wait states once out of reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            hreadyout_ff <= 1'b0;
        end else if (clkEn) begin
            hreadyout_ff <= 1'b1;
        end
    end

    // Response register, every transfer answers OKAY
    always_ff @(posedge mclk) begin
        if (srst) begin
            hresp_ff <= `GIQ_HRESP_OKAY;
        end else if (clkEn) begin
            hresp_ff <= `GIQ_HRESP_OKAY;
        end
    end

    // Mode select, pins 0 to 15
    always_ff @(posedge mclk) begin
        if (srst) begin
            qselLo_ff <= `GIQ_RST_QSEL; // see RULE1
        end else if (clkEn && wrQselLo) begin
            qselLo_ff <= hwdata;
        end
    end

    // Mode select, pins 16 to 31
    always_ff @(posedge mclk) begin
        if (srst) begin
            qselHi_ff <= `GIQ_RST_QSEL; // see RULE1
        end else if (clkEn && wrQselHi) begin
            qselHi_ff <= hwdata;
        end
    end

    // Sampling period bytes, one per group
    always_ff @(posedge mclk) begin
        if (srst) begin
            periodCtl_ff <= `GIQ_RST_CTRL;
        end else if (clkEn && wrCtrl) begin
            periodCtl_ff <= hwdata;
        end
    end

    // Output latch behind the data address
    always_ff @(posedge mclk) begin
        if (srst) begin
            outLatch_ff <= `GIQ_RST_DATA;
        end else if (clkEn && wrData) begin
            outLatch_ff <= hwdata; // see RULE11
        end
    end

    // Route enable per pin
    always_ff @(posedge mclk) begin
        if (srst) begin
            routeEn_ff <= `GIQ_RST_ROUTE;
        end else if (clkEn && wrRoute) begin
            routeEn_ff <= hwdata;
        end
    end

    // Default level per unrouted input
    always_ff @(posedge mclk) begin
        if (srst) begin
            dfltLvl_ff <= `GIQ_RST_DFLT;
        end else if (clkEn && wrDflt) begin
            dfltLvl_ff <= hwdata;
        end
    end

    // One sampler per group of eight pins
    genvar g;
    generate
        for (g = 0; g < `GIQ_NUM_GROUPS; g++) begin : gen_grp
            giq_samp_if sIf ();
            // Period byte g serves pins 8g to 8g+7
            wire [7:0] grpPeriod = periodCtl_ff[g * `GIQ_PERIOD_W +: `GIQ_PERIOD_W];
            assign sIf.period = grpPeriod; // see RULE5
            // Strobe generator for this group
            giq_group_sampler u_samp (
                .mclk(mclk),
                .srst(srst),
                .clkEn(clkEn),
                .port(sIf.smp)
            );
            assign grpTick[g] = sIf.tick;
        end
    endgenerate

    // First synchroniser stage; only the mode 11 bypass also reads the raw pins
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_ff <= 32'h0000_0000;
        end else if (clkEn) begin
            sync1_ff <= pinIn;
        end
    end

    // Second synchroniser stage, the only reader of the first
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync2_ff <= 32'h0000_0000;
        end else if (clkEn) begin
            sync2_ff <= sync1_ff; // see RULE1
        end
    end

    // Per-pin mode, history and qualified level
    logic [63:0] qselAll;
    assign qselAll = {qselHi_ff, qselLo_ff};

    genvar i;
    generate
        for (i = 0; i < `GIQ_NUM_PINS; i++) begin : gen_pin
            // Per-pin working signals
            giq_pkg::giq_qmode_type pinMode;
            logic pinTick;
            logic agree;
            logic nxt_qual;
            logic nxt_periph;
            logic [5:0] nxt_hist;
            logic isAsync;
            logic rawLvl;

            // Mode and strobe for this pin
            assign pinMode = giq_pkg::giq_qmode_type'(qselAll[i * `GIQ_QSEL_W +: `GIQ_QSEL_W]);
            assign pinTick = grpTick[i / `GIQ_GROUP_SIZE]; // see RULE5
            // Sample the synchronised level, never the raw pin
            assign nxt_hist = pinTick ? {hist_ff[i][4:0], sync2_ff[i]} : hist_ff[i]; // see RULE2
            // Three samples span two periods, six span five
            assign agree = windowAgrees(hist_ff[i], pinMode == giq_pkg::GIQ_QUAL6); // see RULE3 RULE8 RULE9

            // Next qualified level by mode
            always_comb begin
                unique case (pinMode)
                    giq_pkg::GIQ_SYNC: nxt_qual = sync2_ff[i]; // see RULE1
                    giq_pkg::GIQ_QUAL3: nxt_qual = agree ? hist_ff[i][0] : qual_ff[i]; // see RULE6
                    giq_pkg::GIQ_QUAL6: nxt_qual = agree ? hist_ff[i][0] : qual_ff[i]; // see RULE6
                    giq_pkg::GIQ_ASYNC: nxt_qual = sync2_ff[i];
                endcase
            end

            // Unrouted inputs take their default level
            assign nxt_periph = routeEn_ff[i] ? nxt_qual : dfltLvl_ff[i]; // see RULE10

            // Sample history, newest at bit 0
            always_ff @(posedge mclk) begin
                if (srst) begin
                    hist_ff[i] <= 6'h00;
                end else if (clkEn) begin
                    hist_ff[i] <= nxt_hist;
                end
            end

            // Qualified level, held in modes 01 and 10 until a window agrees
            always_ff @(posedge mclk) begin
                if (srst) begin
                    qual_ff[i] <= 1'b0;
                end else if (clkEn) begin
                    qual_ff[i] <= nxt_qual; // see RULE6
                end
            end

            // Level handed to the peripheral
            always_ff @(posedge mclk) begin
                if (srst) begin
                    periph_ff[i] <= 1'b0;
                end else if (clkEn) begin
                    periph_ff[i] <= nxt_periph;
                end
            end

            // Unsynchronised mode bypasses every flop
            assign isAsync = (pinMode == giq_pkg::GIQ_ASYNC);
            assign rawLvl = routeEn_ff[i] ? pinIn[i] : dfltLvl_ff[i]; // see RULE10
            assign periphIn[i] = isAsync ? rawLvl : periph_ff[i]; // see RULE4
        end
    endgenerate

    // Bus and latch outputs
    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign pinOutLatch = outLatch_ff;
endmodule : giq_input_qualifier

`default_nettype wire

//--- rtl/giq_consts.svh
// Operation
// RULE1: Mode 00 synchronises only; reset default.
// RULE2: Modes 01, 10 synchronise then qualify.
// RULE3: Mode 01 three samples, 10 six samples.
// RULE4: Mode 11 passes pin unsynchronised.
// RULE5: One sampling period per eight pins.
// RULE6: Output changes only when samples agree.
// RULE7: Period 0 every cycle, else 2n cycles.
// RULE8: Three-sample window spans two periods.
// RULE9: Six-sample window spans five periods.
// RULE10: Unrouted peripheral input takes default level.
// RULE11: Data address: write latch, read pins. Code reads periph_ff, so unrouted pins read their default level.
`ifndef GIQ_CONSTS_SVH
`define GIQ_CONSTS_SVH

// Geometry
`define GIQ_NUM_PINS 32
`define GIQ_GROUP_SIZE 8
`define GIQ_NUM_GROUPS 4
`define GIQ_PERIOD_W 8
`define GIQ_HIST_W 6

// Register byte offsets
`define GIQ_OFF_QSEL_LO 8'h00
`define GIQ_OFF_QSEL_HI 8'h04
`define GIQ_OFF_CTRL 8'h08
`define GIQ_OFF_DATA 8'h0C
`define GIQ_OFF_ROUTE 8'h10
`define GIQ_OFF_DFLT 8'h14

// Reset values
`define GIQ_RST_QSEL 32'h0000_0000
`define GIQ_RST_CTRL 32'h0000_0000
`define GIQ_RST_DATA 32'h0000_0000
`define GIQ_RST_ROUTE 32'hFFFF_FFFF
`define GIQ_RST_DFLT 32'h0000_0000

// Field layout
`define GIQ_QSEL_W 2
`define GIQ_WIN3_W 3
`define GIQ_WIN6_W 6

// AHB codes
`define GIQ_HSIZE_WORD 3'h2
`define GIQ_HRESP_OKAY 1'h0

`endif

//--- rtl/giq_pkg.sv
package giq_pkg;

    // Per-pin input treatment
    typedef enum logic [1:0] {
        GIQ_SYNC = 2'h0,
        GIQ_QUAL3 = 2'h1,
        GIQ_QUAL6 = 2'h2,
        GIQ_ASYNC = 2'h3
    } giq_qmode_type;

endpackage : giq_pkg

//--- rtl/giq_samp_if.sv
`timescale 1ns/1ps
`default_nettype none

// Period setting out to a group sampler, sample strobe back
interface giq_samp_if;
    logic [7:0] period;
    logic tick;
    modport ctl (output period, input tick);
    modport smp (input period, output tick);
endinterface : giq_samp_if

`default_nettype wire

//--- rtl/giq_group_sampler.sv
`timescale 1ns/1ps
`default_nettype none
`include "giq_consts.svh"

module giq_group_sampler (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clkEn,
    giq_samp_if.smp port
);
    logic [8:0] cnt_ff;
    logic tick_ff;

    // Last count of a 2n-cycle period
    wire [8:0] lastCnt = 9'({port.period, 1'b0} - 9'h001);
    wire periodZero = (port.period == 8'h00);
    wire wrap = periodZero || (cnt_ff >= lastCnt); // see RULE7

    // Sample strobe every cycle or every 2n cycles
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_ff <= 9'h000;
            tick_ff <= 1'b0;
        end else if (clkEn) begin
            cnt_ff <= wrap ? 9'h000 : 9'(cnt_ff + 9'h001); // see RULE7
            tick_ff <= wrap;
        end
    end

    assign port.tick = tick_ff;
endmodule : giq_group_sampler

`default_nettype wire

//--- dv/giq_pin_src.sv
`timescale 1ns/1ps
`default_nettype none

module giq_pin_src (
    input wire logic mclk,
    output var logic [31:0] pinIn
);
    // Pins idle low until first driven
    initial pinIn = 32'h0;

    // Outside sources move the pins just after an edge
    task automatic drive(input logic [31:0] v);
        @(posedge mclk);
        pinIn <= v;
    endtask : drive
endmodule : giq_pin_src

`default_nettype wire

//--- dv/giq_input_qualifier_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "giq_consts.svh"

module giq_input_qualifier_sva (
    input wire logic mclk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] pinIn,
    input wire logic [31:0] pinOutLatch,
    input wire logic [31:0] periphIn
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic cfgHi_ff;
    // Address phase decode
    wire logic take = hsel && htrans[1] && hreadyout;
    wire logic wrData = take && hwrite && hsize == `GIQ_HSIZE_WORD && haddr[7:0] == `GIQ_OFF_DATA;
    wire logic rdData = take && !hwrite && haddr[7:0] == `GIQ_OFF_DATA;
    wire logic rdNone = take && !hwrite && haddr[7:0] == 8'h18;
    // Upper mode word has been written
    always_ff @(posedge mclk) cfgHi_ff <= !srst && (cfgHi_ff || (take && hwrite && haddr[7:0] == `GIQ_OFF_QSEL_HI));

    a_resp_okay: assert property (hresp == `GIQ_HRESP_OKAY) else $error("hresp not OKAY");
    a_ready_after: assert property ($past(srst) == 1'h0 |-> hreadyout) else $error("wait state seen");
    a_latch_write: assert property (wrData |-> ##2 pinOutLatch == $past(hwdata))
        else $error("latch missed write");
    a_read_pins: assert property (rdData |=> hrdata[23:0] == $past(periphIn[23:0]))
        else $error("data read not pin state");
    a_unmapped_zero: assert property (rdNone |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_sync_lag: assert property (periphIn[6:0] == $past(pinIn[6:0], 3)) else $error("sync path lag");
    a_async_pass: assert property ($past(cfgHi_ff) |-> periphIn[30:24] == pinIn[30:24])
        else $error("raw pins not passed");
    a_six_agree: assert property ($past(cfgHi_ff) && $changed(periphIn[16]) |->
        periphIn[16] == $past(pinIn[16], 4) && periphIn[16] == $past(pinIn[16], 5)
        && periphIn[16] == $past(pinIn[16], 6) && periphIn[16] == $past(pinIn[16], 7))
        else $error("six sample change without agreement");

    c_read: cover property (rdData);
    c_write: cover property (wrData);
    c_qual: cover property ($past(cfgHi_ff) && $changed(periphIn[16]));
endmodule : giq_input_qualifier_sva

bind giq_input_qualifier giq_input_qualifier_sva u_sva (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pinIn(pinIn), .pinOutLatch(pinOutLatch), .periphIn(periphIn));

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "giq_consts.svh"

module tb_top;
    typedef struct {logic [31:0] a; logic [31:0] e; logic [31:0] m;} giq_note_type;
    logic mclk = 1'h0, srst = 1'h1, clkEn = 1'h1, hsel = 1'h0, hwrite = 1'h0, rdV = 1'h0, rdyN, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, pv, hrdata, pinIn, pinOutLatch, periphIn;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [7:0] n;
    logic [31:0] lat;
    int checks = 0, miscompares = 0;
    giq_note_type expQ[$];
    giq_note_type cur;
    logic [31:0] rstV [7] = '{`GIQ_RST_QSEL, `GIQ_RST_QSEL, `GIQ_RST_CTRL, 32'h0, `GIQ_RST_ROUTE, `GIQ_RST_DFLT, 32'h0};

    giq_input_qualifier u_dut (.mclk(mclk), .srst(srst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pinIn(pinIn), .pinOutLatch(pinOutLatch), .periphIn(periphIn));
    giq_pin_src u_src (.mclk(mclk), .pinIn(pinIn));

    // 200 MHz clock, ready settled for the next edge
    always #2.5 mclk = ~mclk;
    always @(negedge mclk) rdyN = hreadyout;

    // Oldest note against each read data phase
    always @(posedge mclk) begin
        if (rdV && rdyN === 1'h1 && expQ.size() > 0) begin
            cur = expQ.pop_front();
            checks++;
            if ((hrdata & cur.m) !== (cur.e & cur.m)) begin
                miscompares++;
                $display("[ERR] hrdata at %h exp %h seen %h", cur.a, cur.e & cur.m, hrdata & cur.m);
            end
        end
    end

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= `GIQ_HSIZE_WORD;
        // Each phase holds until ready; only the hang guard ends a wait
        do @(posedge mclk); while (rdyN !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        rdV <= !w;
        do @(posedge mclk); while (rdyN !== 1'h1);
        rdV <= 1'h0;
    endtask : xfer

    task automatic rdChk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back('{a, e, m});
        xfer(1'h0, a, 32'h0);
    endtask : rdChk

    task automatic rstSeq;
        repeat (10) @(posedge mclk);
        srst <= 1'h0;
        @(posedge mclk);
    endtask : rstSeq

    task automatic chkRst;
        for (int i = 0; i < 7; i++) rdChk(32'(i * 4), rstV[i], 32'hFFFF_FFFF);
    endtask : chkRst

    task automatic pulse(input logic [31:0] m, input int w);
        u_src.drive(pv | m);
        repeat (w - 1) @(posedge mclk);
        u_src.drive(pv);
        repeat (8) @(posedge mclk);
    endtask : pulse

    task wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // Hang guard
    initial begin
        #50us;
        miscompares++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h22A2));
        n = 8'($urandom_range(3, 1));
        rstSeq();
        chkRst();
        $display("test reset_values done");
        xfer(1'h1, 32'h0, 32'h5555_0000);
        xfer(1'h1, 32'h4, 32'hFFFF_AAAA);
        xfer(1'h1, 32'h8, {16'h0, n, 8'h0});
        xfer(1'h1, 32'h10, 32'hFFFF_FF7F);
        xfer(1'h1, 32'h14, 32'h80);
        lat = $urandom();
        xfer(1'h1, 32'hC, lat);
        rdChk(32'h8, {16'h0, n, 8'h0}, 32'hFFFF_FFFF);
        rdChk(32'hC, 32'h80, 32'h00FF_FFFF);
        @(negedge mclk);
        checks++;
        if (pinOutLatch !== lat) begin
            miscompares++;
            $display("[ERR] pinOutLatch exp %h seen %h", lat, pinOutLatch);
        end
        $display("test config done");
        pv = 32'($urandom_range(127, 0));
        u_src.drive(pv);
        repeat (4) @(posedge mclk);
        rdChk(32'hC, pv | 32'h80, 32'hFF);
        pulse(32'h8100, 4 * n);
        rdChk(32'hC, 32'h0, 32'h8100);
        pulse(32'h1_0000, 5);
        rdChk(32'hC, 32'h0, 32'h1_0000);
        pv = pv | 32'h7F01_8100;
        u_src.drive(pv);
        repeat (6 * n + 9) @(posedge mclk);
        rdChk(32'hC, pv, 32'h1_8100);
        $display("test qualify done");
        pv = 32'h0;
        u_src.drive(pv);
        srst <= 1'h1;
        rstSeq();
        chkRst();
        $display("test second_reset done");
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
